// ==== pges_event_status.sv ====
// gpio trigger and capture event flags, interrupt status and host interrupt
// assumes apb master in the same clock domain; event inputs from same-clock logic
`timescale 1ns/100ps
`include "pges_defs.svh"
module pges_event_status
    import pges_pkg::*;
#(
    parameter int N_TRIG = 3,
    parameter int N_CAP  = 2
) (
    input  wire logic              CLK_I,
    input  wire logic              RESET_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [11:0]       PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic [N_TRIG-1:0] TRIG_FIRED_I,
    input  wire logic [N_TRIG-1:0] TRIG_LATE_I,
    input  wire logic [N_CAP-1:0]  CAP_EVENT_I,
    output logic      [N_TRIG-1:0] TRIG_ARM_O,
    output logic                   GLOBAL_STAT_O,
    output logic                   IRQ_O
);
    // ==========================================================
    // bus decode
    pges_apb_req_t req;
    logic          wr_acc;
    logic          rd_acc;
    logic          hit_flags;
    logic          hit_stat;
    logic          hit_ctrl;
    logic          hit_mask;
    logic          hit_any;

    assign req       = '{psel: PSEL_I, penable: PENABLE_I, pwrite: PWRITE_I,
                         paddr: PADDR_I, pwdata: PWDATA_I};
    // exact word match: byte lanes are not decoded, so only aligned word offsets hit
    function automatic logic f_hit(input logic [11:0] addr, input logic [11:0] off);
        return addr == off;
    endfunction : f_hit

    assign hit_flags = f_hit(req.paddr, `PGES_OFF_FLAGS);
    assign hit_stat  = f_hit(req.paddr, `PGES_OFF_IRQ_STAT);
    assign hit_ctrl  = f_hit(req.paddr, `PGES_OFF_CTRL);
    assign hit_mask  = f_hit(req.paddr, `PGES_OFF_IRQ_MASK);
    assign hit_any   = hit_flags | hit_stat | hit_ctrl | hit_mask;
    assign wr_acc    = req.psel & req.penable & req.pwrite & hit_any;
    assign rd_acc    = req.psel & req.penable & ~req.pwrite;
    assign PREADY_O  = 1'b1;
    // unmapped addresses answer with an error, but in the same cycle
    assign PSLVERR_O = req.psel & req.penable & ~hit_any;

    // ==========================================================
    // control: arm, notify-on-fire, capture allow
    logic [N_TRIG-1:0] arm_r;
    logic [N_TRIG-1:0] arm_nxt;
    logic [N_TRIG-1:0] notify_r;
    logic [N_CAP-1:0]  allow_r;
    logic [4:0]        mask_r;
    logic              wr_ctrl;
    logic [N_TRIG-1:0] arm_wr;
    logic [N_TRIG-1:0] arm_drop;

    assign wr_ctrl  = wr_acc & hit_ctrl;
    assign arm_wr   = PWDATA_I[`PGES_CTL_ARM_LSB +: N_TRIG];
    // a write of zero to an armed unit drops it and clears its miss flag
    assign arm_drop = wr_ctrl ? ~arm_wr : '0;
    // firing self-disarms; a firing in the write cycle still wins
    assign arm_nxt  = (wr_ctrl ? arm_wr : arm_r) & ~TRIG_FIRED_I;

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            arm_r    <= '0;
            notify_r <= '0;
            allow_r  <= '0;
            mask_r   <= `PGES_RST_MASK;
        end else begin
            arm_r <= arm_nxt;
            if (wr_ctrl) begin
                notify_r <= PWDATA_I[`PGES_CTL_NOTIFY_LSB +: N_TRIG];
                allow_r  <= PWDATA_I[`PGES_CTL_ALLOW_LSB +: N_CAP];
            end
            if (wr_acc && hit_mask) begin
                mask_r <= PWDATA_I[4:0];
            end
        end
    end
    assign TRIG_ARM_O = arm_r;

    // ==========================================================
    // event flags
    pges_evt_t         evt;
    logic [N_TRIG-1:0] done_q;
    logic [N_TRIG-1:0] miss_q;
    logic [N_TRIG-1:0] done_clr;
    logic [N_TRIG-1:0] miss_clr;
    logic              wr_flags;

    // only gpio capture events enter; egress timestamps have their own path
    assign evt.captured = CAP_EVENT_I & allow_r;
    assign evt.fired    = TRIG_FIRED_I & notify_r;
    assign evt.late     = TRIG_LATE_I & notify_r & arm_r;
    assign wr_flags     = wr_acc & hit_flags;
    assign done_clr     = wr_flags ? PWDATA_I[`PGES_FLG_DONE_LSB +: N_TRIG] : '0;
    assign miss_clr     = (wr_flags ? PWDATA_I[`PGES_FLG_MISS_LSB +: N_TRIG] : '0) | arm_drop;

    pges_sticky #(.W(N_TRIG)) u_done (
        .clk_i (CLK_I),
        .rst_i (RESET_I),
        .set_i (evt.fired),
        .clr_i (done_clr),
        .q_o   (done_q)
    );
    pges_sticky #(.W(N_TRIG)) u_miss (
        .clk_i (CLK_I),
        .rst_i (RESET_I),
        .set_i (evt.late),
        .clr_i (miss_clr),
        .q_o   (miss_q)
    );

    // ==========================================================
    // interrupt status
    logic [N_TRIG-1:0] tirq_q;
    logic [N_CAP-1:0]  cirq_q;
    logic [N_TRIG-1:0] tirq_set;
    logic [N_TRIG-1:0] tirq_clr;
    logic [N_CAP-1:0]  cirq_clr;
    logic              wr_stat;

    assign wr_stat  = wr_acc & hit_stat;
    assign tirq_set = evt.fired | evt.late;
    // write-one clears, so other bits are untouched by a partial write
    assign tirq_clr = wr_stat ? PWDATA_I[`PGES_IRQ_TRIG_LSB +: N_TRIG] : '0;
    assign cirq_clr = wr_stat ? PWDATA_I[`PGES_IRQ_CAP_LSB +: N_CAP] : '0;

    pges_sticky #(.W(N_TRIG)) u_tirq (
        .clk_i (CLK_I),
        .rst_i (RESET_I),
        .set_i (tirq_set),
        .clr_i (tirq_clr),
        .q_o   (tirq_q)
    );
    pges_sticky #(.W(N_CAP)) u_cirq (
        .clk_i (CLK_I),
        .rst_i (RESET_I),
        .set_i (evt.captured),
        .clr_i (cirq_clr),
        .q_o   (cirq_q)
    );

    logic [4:0] stat_all;
    assign stat_all      = {tirq_q, cirq_q};
    assign GLOBAL_STAT_O = |stat_all;
    assign IRQ_O         = |(stat_all & mask_r);

    // ==========================================================
    // read data, registered on the setup phase
    logic [31:0] rd_nxt;
    logic [31:0] prdata_r;

    assign rd_nxt = hit_flags ? ({13'h0, miss_q, 13'h0, done_q}) :
                    hit_stat  ? ({13'h0, tirq_q, 14'h0, cirq_q}) :
                    hit_ctrl  ? ({22'h0, allow_r, 1'b0, notify_r, 1'b0, arm_r}) :
                    hit_mask  ? ({27'h0, mask_r}) : 32'h0;

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            prdata_r <= 32'h0;
        end else if (req.psel && !req.penable && !req.pwrite) begin
            prdata_r <= rd_nxt;
        end
    end
    assign PRDATA_O = prdata_r;

    // ==========================================================
    // checks
    // a read is latched on its setup edge, so the access phase must show what setup saw
    sequence s_rd_setup;
        req.psel && !req.penable && !req.pwrite;
    endsequence

    sequence s_rd_access;
        rd_acc;
    endsequence

    sequence s_rd_flags;
        (req.psel && !req.penable && !req.pwrite && hit_flags) ##1 (rd_acc && hit_flags);
    endsequence

    property p_rd_data;
        @(posedge CLK_I) disable iff (RESET_I)
        s_rd_setup ##1 s_rd_access |-> PRDATA_O == $past(rd_nxt);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data not held");

    property p_flags_reserved;
        @(posedge CLK_I) disable iff (RESET_I)
        s_rd_flags |-> (PRDATA_O[31:19] == 13'h0 && PRDATA_O[15:3] == 13'h0);
    endproperty
    a_flags_reserved: assert property (p_flags_reserved) else $error("reserved flag bits set");

    property p_miss_set;
        @(posedge CLK_I) disable iff (RESET_I)
        (TRIG_LATE_I[0] && notify_r[0] && arm_r[0]) |=> miss_q[0];
    endproperty
    a_miss_set: assert property (p_miss_set) else $error("miss flag not set");

    property p_arm_zero_clears;
        @(posedge CLK_I) disable iff (RESET_I)
        (wr_ctrl && !arm_wr[1] && !(TRIG_LATE_I[1] && notify_r[1] && arm_r[1])) |=> !miss_q[1];
    endproperty
    a_arm_zero_clears: assert property (p_arm_zero_clears) else $error("miss flag kept");

    property p_no_notify;
        @(posedge CLK_I) disable iff (RESET_I)
        (!notify_r[2] && !tirq_q[2]) ##1 !$past(notify_r[2]) |-> !tirq_q[2];
    endproperty
    a_no_notify: assert property (p_no_notify) else $error("irq without notify");

    property p_done_set;
        @(posedge CLK_I) disable iff (RESET_I)
        (TRIG_FIRED_I[0] && notify_r[0]) |=> (done_q[0] && tirq_q[0]);
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");

    property p_cap_gate;
        @(posedge CLK_I) disable iff (RESET_I)
        (CAP_EVENT_I[1] && allow_r[1]) |=> cirq_q[1];
    endproperty
    a_cap_gate: assert property (p_cap_gate) else $error("capture irq lost");

    property p_global_or;
        @(posedge CLK_I) disable iff (RESET_I)
        GLOBAL_STAT_O == ((|tirq_q) || (|cirq_q));
    endproperty
    a_global_or: assert property (p_global_or) else $error("global status wrong");

    property p_reserved_zero;
        @(posedge CLK_I) disable iff (RESET_I)
        $past(req.psel && !req.penable && !req.pwrite && hit_stat)
            |-> (PRDATA_O[15:2] == 14'h0 && PRDATA_O[31:19] == 13'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_self_disarm;
        @(posedge CLK_I) disable iff (RESET_I)
        TRIG_FIRED_I[2] |=> !arm_r[2];
    endproperty
    a_self_disarm: assert property (p_self_disarm) else $error("arm not cleared");

    property p_set_wins;
        @(posedge CLK_I) disable iff (RESET_I)
        (wr_stat && PWDATA_I[16] && evt.fired[0]) |=> tirq_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

    property p_irq_level;
        @(posedge CLK_I) disable iff (RESET_I)
        (GLOBAL_STAT_O && mask_r == 5'h1f) |-> IRQ_O;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq dropped");

    // clear checks leave out a same-cycle set, since a set wins over any clear
    property p_done_w1c;
        @(posedge CLK_I) disable iff (RESET_I)
        (wr_flags && PWDATA_I[`PGES_FLG_DONE_LSB + 1] && !evt.fired[1]) |=> !done_q[1];
    endproperty
    a_done_w1c: assert property (p_done_w1c) else $error("done flag not cleared");

    property p_miss_w1c;
        @(posedge CLK_I) disable iff (RESET_I)
        (wr_flags && PWDATA_I[`PGES_FLG_MISS_LSB] && !evt.late[0]) |=> !miss_q[0];
    endproperty
    a_miss_w1c: assert property (p_miss_w1c) else $error("miss flag not cleared");

    property p_stat_w1c;
        @(posedge CLK_I) disable iff (RESET_I)
        (wr_stat && PWDATA_I[`PGES_IRQ_CAP_LSB] && !evt.captured[0]) |=> !cirq_q[0];
    endproperty
    a_stat_w1c: assert property (p_stat_w1c) else $error("capture status not cleared");

    property p_trig_stat_w1c;
        @(posedge CLK_I) disable iff (RESET_I)
        (wr_stat && PWDATA_I[`PGES_IRQ_TRIG_LSB + 2] && !tirq_set[2]) |=> !tirq_q[2];
    endproperty
    a_trig_stat_w1c: assert property (p_trig_stat_w1c) else $error("trigger status not cleared");

    property p_arm_drop_unit2;
        @(posedge CLK_I) disable iff (RESET_I)
        (wr_ctrl && !arm_wr[2] && !evt.late[2]) |=> !miss_q[2];
    endproperty
    a_arm_drop_unit2: assert property (p_arm_drop_unit2) else $error("miss flag kept after disarm");

    property p_no_notify_done;
        @(posedge CLK_I) disable iff (RESET_I)
        (!notify_r[1] && !done_q[1]) |=> !done_q[1];
    endproperty
    a_no_notify_done: assert property (p_no_notify_done) else $error("done flag without notify");

    property p_late_needs_arm;
        @(posedge CLK_I) disable iff (RESET_I)
        (!arm_r[0] && !miss_q[0]) |=> !miss_q[0];
    endproperty
    a_late_needs_arm: assert property (p_late_needs_arm) else $error("miss flag on idle unit");

    property p_cap_blocked;
        @(posedge CLK_I) disable iff (RESET_I)
        (!allow_r[0] && !cirq_q[0]) |=> !cirq_q[0];
    endproperty
    a_cap_blocked: assert property (p_cap_blocked) else $error("capture irq while not allowed");

    property p_late_status;
        @(posedge CLK_I) disable iff (RESET_I)
        evt.late[1] |=> (tirq_q[1] && miss_q[1]);
    endproperty
    a_late_status: assert property (p_late_status) else $error("late event not reported");

    property p_cap_global;
        @(posedge CLK_I) disable iff (RESET_I)
        evt.captured[1] |=> GLOBAL_STAT_O;
    endproperty
    a_cap_global: assert property (p_cap_global) else $error("capture missing from global status");

    // an unmasked bit can only come from a pending status bit, so a quiet status means a quiet pin
    property p_irq_quiet;
        @(posedge CLK_I) disable iff (RESET_I)
        !GLOBAL_STAT_O |-> !IRQ_O;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq without pending status");
endmodule : pges_event_status

// ==== pges_defs.svh ====
// register offsets, field positions and reset values of the gpio event status block
// assumes a 32-bit apb slave decoding byte addresses
`ifndef PGES_DEFS_SVH
`define PGES_DEFS_SVH

`define PGES_OFF_FLAGS      12'h524
`define PGES_OFF_IRQ_STAT   12'h528
`define PGES_OFF_CTRL       12'h540
`define PGES_OFF_IRQ_MASK   12'h544

`define PGES_FLG_DONE_LSB   0
`define PGES_FLG_MISS_LSB   16
`define PGES_IRQ_CAP_LSB    0
`define PGES_IRQ_TRIG_LSB   16
`define PGES_CTL_ARM_LSB    0
`define PGES_CTL_NOTIFY_LSB 4
`define PGES_CTL_ALLOW_LSB  8

`define PGES_RST_TRIG       3'h0
`define PGES_RST_CAP        2'h0
`define PGES_RST_MASK       5'h1f

`endif

// ==== pges_pkg.sv ====
// types shared by the gpio event status block
// assumes pges_defs.svh holds the numbers
package pges_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pges_apb_req_t;

    typedef struct packed {
        logic [2:0] fired;
        logic [2:0] late;
        logic [1:0] captured;
    } pges_evt_t;
endpackage : pges_pkg

// ==== pges_sticky.sv ====
// one row of sticky flags: set beats clear
// assumes set and clear are single-cycle strobes in the clk domain
`timescale 1ns/100ps
module pges_sticky #(
    parameter int W = 3
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    assign q_nxt = set_i | (q_r & ~clr_i);
    assign q_o   = q_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule : pges_sticky

// ==== tb.sv ====
// self-checking bench for the gpio event status block
// assumes pges_event_status with default unit counts and apb slave at byte addresses
`timescale 1ns/100ps
module tb import pges_pkg::*;;
    logic        CLK_I, RESET_I, PSEL_I, PENABLE_I, PWRITE_I;
    logic [11:0] PADDR_I;
    logic [31:0] PWDATA_I, PRDATA_O;
    logic        PREADY_O, PSLVERR_O, GLOBAL_STAT_O, IRQ_O;
    logic [2:0]  TRIG_FIRED_I, TRIG_LATE_I, TRIG_ARM_O, f, l;
    logic [1:0]  CAP_EVENT_I, c;
    logic [31:0] m_flags, m_irq, m_ctrl, m_mask, fl, ir, ct, rdata;
    logic [4:0]  pend;
    logic        wr;
    int          err_total, checked, i;
    logic [11:0] addrs [5] = '{12'h524, 12'h528, 12'h540, 12'h544, 12'h52c};

    pges_event_status u_pges_event_status (.CLK_I(CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
        .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
        .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TRIG_FIRED_I(TRIG_FIRED_I),
        .TRIG_LATE_I(TRIG_LATE_I), .CAP_EVENT_I(CAP_EVENT_I), .TRIG_ARM_O(TRIG_ARM_O),
        .GLOBAL_STAT_O(GLOBAL_STAT_O), .IRQ_O(IRQ_O));

    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end

    // ==========================================
    // reference model, fed by the sampled inputs
    // ==========================================
    always @(posedge CLK_I) begin
        if (RESET_I) begin
            m_flags <= 32'h0; m_irq <= 32'h0; m_ctrl <= 32'h0; m_mask <= 32'h1f;
        end else begin
            wr = PSEL_I && PENABLE_I && PWRITE_I;
            f  = TRIG_FIRED_I & m_ctrl[6:4];
            l  = TRIG_LATE_I & m_ctrl[6:4] & m_ctrl[2:0];
            c  = CAP_EVENT_I & m_ctrl[9:8];
            fl = m_flags; ir = m_irq; ct = m_ctrl;
            if (wr && PADDR_I == 12'h524) fl = fl & ~PWDATA_I;
            if (wr && PADDR_I == 12'h528) ir = ir & ~PWDATA_I;
            if (wr && PADDR_I == 12'h540) begin
                ct = PWDATA_I & 32'h377;
                fl[18:16] = fl[18:16] & ct[2:0];
            end
            if (wr && PADDR_I == 12'h544) m_mask <= PWDATA_I & 32'h1f;
            ct[2:0] = ct[2:0] & ~TRIG_FIRED_I;
            // sets applied last so a same-cycle clear never loses an event
            m_flags <= fl | {13'h0, l, 13'h0, f};
            m_irq <= ir | {13'h0, f | l, 14'h0, c};
            m_ctrl <= ct;
        end
    end

    function logic [31:0] exp_rd(input logic [11:0] a);
        case (a)
            12'h524: exp_rd = m_flags;
            12'h528: exp_rd = m_irq;
            12'h540: exp_rd = m_ctrl;
            12'h544: exp_rd = m_mask;
            default: exp_rd = 32'h0;
        endcase
    endfunction : exp_rd

    // ==========================================
    // compares and closing
    // ==========================================
    task cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : cmp_rd

    task cmp_pin(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: pins %h expected %h", $time, got, exp);
        end
    endtask : cmp_pin

    task conclude();
        $display("Comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude

    // ==========================================
    // bus and event drivers
    // ==========================================
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge CLK_I);
        PSEL_I <= 1'b1; PWRITE_I <= w; PADDR_I <= a; PWDATA_I <= d;
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK_I);
            n++;
        end while (PREADY_O !== 1'b1 && n < 20);
        if (PREADY_O !== 1'b1) begin
            err_total++;
            conclude();
        end else begin
            r = PRDATA_O;
            cmp_pin({31'h0, PSLVERR_O}, {31'h0, exp_rd(a) === 32'h0 && a == 12'h52c});
            PSEL_I <= 1'b0; PENABLE_I <= 1'b0;
        end
    endtask : apb

    // event pulse timed to land on the access edge of the write
    task collide(input logic [11:0] a, input logic [31:0] d, input logic [2:0] tf, input logic [2:0] tl,
                 input logic [1:0] tc);
        fork
            apb(1'b1, a, d, rdata);
            begin
                repeat (2) @(posedge CLK_I);
                TRIG_FIRED_I <= tf; TRIG_LATE_I <= tl; CAP_EVENT_I <= tc;
                @(posedge CLK_I);
                TRIG_FIRED_I <= 3'h0; TRIG_LATE_I <= 3'h0; CAP_EVENT_I <= 2'h0;
            end
        join
    endtask : collide

    task rd_all();
        @(negedge CLK_I);
        pend = {m_irq[18:16], m_irq[1:0]};
        cmp_pin({27'h0, GLOBAL_STAT_O, IRQ_O, TRIG_ARM_O}, {27'h0, |pend, |(pend & m_mask[4:0]), m_ctrl[2:0]});
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, addrs[k], 32'h0, rdata);
            cmp_rd(rdata, exp_rd(addrs[k]));
        end
    endtask : rd_all

    initial begin
        repeat (100000) @(posedge CLK_I);
        err_total++;
        conclude();
    end

    // ==========================================
    // main sequence
    // ==========================================
    initial begin
        void'($urandom(46688));
        RESET_I = 1'b1; PSEL_I = 1'b0; PENABLE_I = 1'b0; PWRITE_I = 1'b0; PADDR_I = 12'h0;
        PWDATA_I = 32'h0; TRIG_FIRED_I = 3'h0; TRIG_LATE_I = 3'h0; CAP_EVENT_I = 2'h0;
        err_total = 0; checked = 0;
        repeat (4) @(posedge CLK_I);
        RESET_I <= 1'b0;
        rd_all();
        apb(1'b1, 12'h540, 32'h377, rdata);
        collide(12'h524, 32'hffffffff, 3'h5, 3'h0, 2'h0);
        collide(12'h528, 32'hffffffff, 3'h0, 3'h0, 2'h3);
        apb(1'b1, 12'h540, 32'h377, rdata);
        collide(12'h540, 32'h370, 3'h0, 3'h7, 2'h0);
        rd_all();
        for (i = 0; i < 250; i++) begin
            if ($urandom % 2) begin
                // units armed with notify off are kept from firing, so a firing unit with notify off is never armed
                collide(12'h52c, 32'h0, 3'($urandom) & ~(m_ctrl[2:0] & ~m_ctrl[6:4]), 3'($urandom), 2'($urandom));
            end else begin
                apb(1'b1, addrs[$urandom % 5], $urandom, rdata);
            end
            rd_all();
        end
        conclude();
    end
endmodule : tb
